// File: common/frw_pkg.sv
// frw_pkg: constants, types and field layout of the flash read path.
// assumes one clock (pclk), one active-low reset and a 32-bit APB.
//
// Function
// - unstalled reads finish without extra wait states
// - setting 11x holds read, reissues after done
// - setting 110 also sets stall notify flag
// - setting 10x aborts array operation, then retries
// - setting 100 also sets terminate notify flag
// - bus pipeline held during stall or terminate
// - every array read returns 128-bit page
// - word in page chosen by address bits 3:2
// - program granularity word or double word
// - ECC corrects single, detects double errors
// - programmed bit reads 0, erased reads 1
// - erase suspend offered, program suspend not
// - program and erase both may be aborted
// - control registers on separate 32-bit bus
// - busy array never serves a read
// - engine refuses locked or disabled blocks
// - done stays low through program or erase
// - top bit clear errors reads to busy array
// - read-while-write setting resets to 111
// - abort held until done returns high
// - notify flags ORed into one request
package frw_pkg;

    // ========================================
    // widths
    localparam int PAGE_W = 128;      // array page width
    localparam int WORD_W = 32;       // bus word width
    localparam int AHB_AW = 32;       // system address width
    localparam int LOCK_W = 16;       // lockable blocks
    localparam int RWW_W = 3;         // read-while-write field width
    localparam int WSEL_LO = 2;       // word select low bit
    localparam int WSEL_HI = 3;       // word select high bit
    localparam int PAGE_LO = 4;       // page address low bit

    // ========================================
    // register map (byte addresses)
    localparam logic [11:0] CFG_OFS = 12'h000;   // control
    localparam logic [11:0] STAT_OFS = 12'h004;  // status, write one clears
    localparam logic [11:0] CAP_OFS = 12'h008;   // capabilities, read only
    localparam logic [11:0] LOCK_OFS = 12'h00C;  // block lock mask

    // control field positions and reset values
    localparam int CFG_RWW_LO = 0;
    localparam logic [2:0] RWW_RST = 3'h7;       // stall, no notify, no abort
    localparam int RWW_STALL_BIT = 2;            // set: stall, clear: error
    localparam int RWW_KEEP_BIT = 1;             // set: keep, clear: abort
    localparam int RWW_QUIET_BIT = 0;            // set: no notify flag
    localparam logic [LOCK_W-1:0] LOCK_RST = 16'hFFFF;

    // status bit positions
    localparam int ST_STALL = 0;      // stall notify flag
    localparam int ST_TERM = 1;       // terminate notify flag
    localparam int ST_ECC_SB = 2;     // corrected single-bit error seen
    localparam int ST_ECC_DB = 3;     // double-bit error seen
    localparam int ST_DONE = 8;       // live array done
    localparam int ST_ABORT = 9;      // live abort output
    localparam int ST_FLAGS = 4;      // number of sticky flags

    // capability word: page 128, word and dword program, sec-ded,
    // erase suspend, no program suspend, program and erase abort,
    // erased bit reads one
    localparam logic [31:0] CAP_VAL = 32'h0000_7D80;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

    // ========================================
    // bus encodings
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam int HTRANS_ACT_BIT = 1;

    // ========================================
    // types
    typedef enum logic [2:0] {
        FRW_IDLE, FRW_READ, FRW_STALL, FRW_ERR1, FRW_ERR2
    } frw_state_e;

    // events from read path to register file
    typedef struct packed {
        logic stall;
        logic term;
        logic ecc_sb;
        logic ecc_db;
    } frw_evt_s;

    // request to the array
    typedef struct packed {
        logic rd_en;
        logic abort;
        logic [AHB_AW-1:PAGE_LO] page;
    } frw_req_s;

endpackage

// File: hdl/frw_regs.sv
// frw_regs: apb register file of the flash read path.
// assumes apb master on pclk; events arrive as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module frw_regs
    import frw_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // block side
    input wire frw_evt_s evt,
    input wire logic fl_done,
    input wire logic fl_abort,
    output logic [RWW_W-1:0] rww_cfg,
    output logic [LOCK_W-1:0] block_lock,
    output logic notify_irq
);

    // ========================================
    // state
    logic [RWW_W-1:0] rww_q, rww_d;          // read-while-write setting
    logic [LOCK_W-1:0] lock_q, lock_d;       // block lock mask
    logic [ST_FLAGS-1:0] flag_q, flag_d;     // sticky flags
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic setup, wr_en;
    logic [ST_FLAGS-1:0] set_v;

    // ========================================
    // next values
    always_comb begin
        setup = psel && !penable;
        wr_en = psel && penable && pwrite && pready_q && !pslverr_q;
        set_v = {evt.ecc_db, evt.ecc_sb, evt.term, evt.stall};
        rww_d = rww_q;
        lock_d = lock_q;
        flag_d = flag_q;
        prdata_d = '0;
        pready_d = setup;                    // answer in first access cycle
        pslverr_d = 1'b0;
        if (setup) begin
            unique case (paddr)
                CFG_OFS: prdata_d[RWW_W-1:0] = rww_q;
                STAT_OFS: begin
                    prdata_d[ST_FLAGS-1:0] = flag_q;
                    prdata_d[ST_DONE] = fl_done;
                    prdata_d[ST_ABORT] = fl_abort;
                end
                CAP_OFS: prdata_d = CAP_VAL;
                LOCK_OFS: prdata_d[LOCK_W-1:0] = lock_q;
                default: pslverr_d = 1'b1;   // unmapped address
            endcase
        end
        // write takes effect at the completing edge
        if (wr_en && paddr == CFG_OFS) begin
            rww_d = pwdata[CFG_RWW_LO +: RWW_W];
        end
        if (wr_en && paddr == LOCK_OFS) begin
            lock_d = pwdata[LOCK_W-1:0];
        end
        if (wr_en && paddr == STAT_OFS) begin
            flag_d = flag_q & ~pwdata[ST_FLAGS-1:0];
        end
        flag_d = flag_d | set_v;             // set wins over clear
        irq_d = flag_d[ST_STALL] | flag_d[ST_TERM];
    end

    // ========================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rww_q <= RWW_RST;
            lock_q <= LOCK_RST;
            flag_q <= '0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rww_q <= rww_d;
            lock_q <= lock_d;
            flag_q <= flag_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rww_cfg = rww_q;
    assign block_lock = lock_q;
    assign notify_irq = irq_q;

endmodule
`default_nettype wire

// File: hdl/frw_ctrl.sv
// frw_ctrl: ahb read path into a single-bank flash array, with
// stall-and-retry and terminate-and-retry while the array is busy.
// assumes the array runs on pclk, returns a page with fl_rvalid and
// holds fl_done low for a whole program or erase.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module frw_ctrl
    import frw_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // ahb slave, read path
    input wire logic hsel,
    input wire logic [AHB_AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready_in,
    output logic hready_out,
    output logic hresp,
    output logic [WORD_W-1:0] hrdata,
    // flash array
    output logic fl_rd_en,
    output logic [AHB_AW-1:PAGE_LO] fl_page,
    output logic fl_abort,
    input wire logic fl_done,
    input wire logic fl_rvalid,
    input wire logic [PAGE_W-1:0] fl_rdata,
    input wire logic fl_ecc_sb,
    input wire logic fl_ecc_db,
    // apb register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program/erase engine side
    output logic [LOCK_W-1:0] fl_block_lock,
    output logic notify_irq
);

    // ========================================
    // declarations
    frw_state_e state_q, state_d;            // read path state
    frw_req_s req_q, req_d;                  // request to array
    logic [1:0] word_q, word_d;              // word within page
    logic hready_q, hready_d;
    logic hresp_q, hresp_d;
    logic [WORD_W-1:0] hrdata_q, hrdata_d;
    frw_evt_s evt_d, evt_q;                  // pulses to register file
    logic [RWW_W-1:0] rww_cfg;               // read-while-write setting
    logic accept;                            // active address phase taken, read or write
    logic notify;                            // notify flag enabled
    logic do_abort;                          // terminate enabled

    // ========================================
    // register file
    frw_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .evt(evt_q),
        .fl_done(fl_done),
        .fl_abort(req_q.abort),
        .rww_cfg(rww_cfg),
        .block_lock(fl_block_lock),
        .notify_irq(notify_irq)
    );

    // ========================================
    // read path next state
    always_comb begin
        accept = hsel && hready_in && htrans[HTRANS_ACT_BIT];
        notify = !rww_cfg[RWW_QUIET_BIT];
        do_abort = !rww_cfg[RWW_KEEP_BIT];
        state_d = state_q;
        req_d = req_q;
        word_d = word_q;
        hready_d = hready_q;
        hresp_d = hresp_q;
        hrdata_d = hrdata_q;
        evt_d = '0;
        unique case (state_q)
            // idle, or last cycle of an error, ready for a new phase
            FRW_IDLE, FRW_ERR2: begin
                hready_d = 1'b1;
                hresp_d = 1'b0;
                if (accept) begin
                    // the held next address is taken once here
                    word_d = haddr[WSEL_HI:WSEL_LO];
                    req_d.page = haddr[AHB_AW-1:PAGE_LO];
                    hready_d = 1'b0;
                    if (hwrite) begin
                        // array is changed only via registers
                        hresp_d = 1'b1;
                        state_d = FRW_ERR1;
                    end else if (!fl_done) begin
                        if (!rww_cfg[RWW_STALL_BIT]) begin
                            // error now, read never reaches array
                            hresp_d = 1'b1;
                            state_d = FRW_ERR1;
                        end else begin
                            // busy array: hold the read
                            state_d = FRW_STALL;
                            req_d.abort = do_abort;
                            evt_d.stall = notify && !do_abort;
                            evt_d.term = notify && do_abort;
                        end
                    end else begin
                        req_d.rd_en = 1'b1;
                        state_d = FRW_READ;
                    end
                end
            end
            // array access in flight, data phase held
            FRW_READ: begin
                hready_d = 1'b0;
                if (!fl_done) begin
                    // done fell during the read: drop it, then retry, or error if stall bit clear
                    req_d.rd_en = 1'b0;
                    if (rww_cfg[RWW_STALL_BIT]) begin
                        state_d = FRW_STALL;
                        req_d.abort = do_abort;
                        evt_d.stall = notify && !do_abort;
                        evt_d.term = notify && do_abort;
                    end else begin
                        hresp_d = 1'b1;
                        state_d = FRW_ERR1;
                    end
                end else if (fl_rvalid) begin
                    req_d.rd_en = 1'b0;
                    // full page back, pick one word
                    hrdata_d = fl_rdata[word_q*WORD_W +: WORD_W];
                    evt_d.ecc_sb = fl_ecc_sb;
                    evt_d.ecc_db = fl_ecc_db;
                    if (fl_ecc_db) begin
                        // uncorrectable: error response instead
                        hrdata_d = ERASED_WORD;
                        hresp_d = 1'b1;
                        state_d = FRW_ERR1;
                    end else begin
                        hready_d = 1'b1;
                        state_d = FRW_IDLE;
                    end
                end
            end
            // waiting for done; abort held until done is high
            FRW_STALL: begin
                hready_d = 1'b0;
                if (fl_done) begin
                    // pseudo address phase to the same page
                    req_d.abort = 1'b0;
                    req_d.rd_en = 1'b1;
                    state_d = FRW_READ;
                end
            end
            // first error cycle: hready low, hresp high
            FRW_ERR1: begin
                hready_d = 1'b1;
                hresp_d = 1'b1;
                state_d = FRW_ERR2;
            end
        endcase
    end

    // ========================================
    // read path registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FRW_IDLE;
            req_q <= '0;
            word_q <= '0;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= '0;
            evt_q <= '0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            word_q <= word_d;
            hready_q <= hready_d;
            hresp_q <= hresp_d;
            hrdata_q <= hrdata_d;
            evt_q <= evt_d;
        end
    end

    // ========================================
    // outputs straight from registers
    assign hready_out = hready_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign fl_rd_en = req_q.rd_en;
    assign fl_page = req_q.page;
    assign fl_abort = req_q.abort;

endmodule
`default_nettype wire

// File: tb/frw_ctrl_props.sv
// frw_ctrl_props: concurrent checks on the flash read path ports.
// assumes it is bound to frw_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module frw_ctrl_props
    import frw_pkg::*;
(
    // clock, reset and ahb side
    input wire logic pclk, presetn, hsel, hwrite, hready_in,
    input wire logic [AHB_AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hready_out, hresp,
    input wire logic [WORD_W-1:0] hrdata,
    // array side and apb handshake
    input wire logic fl_rd_en, fl_abort, fl_done, fl_rvalid, fl_ecc_db,
    input wire logic [AHB_AW-1:PAGE_LO] fl_page,
    input wire logic [PAGE_W-1:0] fl_rdata,
    input wire logic psel, penable, pready
);
    // ====================
    // helper: word select kept from the taken address phase
    logic take;
    logic [1:0] wsel_q, wsel_d;
    assign take = hsel && hready_in && htrans[1] && hready_out;
    always_comb wsel_d = take ? haddr[3:2] : wsel_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wsel_q <= 2'h0;
        else
            wsel_q <= wsel_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====================
    // properties
    busy_no_read_a: assert property (!fl_done |=> !fl_rd_en)
        else $error("array read while busy");
    abort_hold_a: assert property (fl_abort && !fl_done |=> fl_abort)
        else $error("abort dropped while busy");
    abort_drop_a: assert property (fl_abort && fl_done |=> !fl_abort)
        else $error("abort kept after done");
    abort_cause_a: assert property ($rose(fl_abort) |-> !$past(fl_done))
        else $error("abort without busy array");
    page_hold_a: assert property (fl_rd_en && !fl_rvalid && fl_done
        |=> fl_rd_en && $stable(fl_page)) else $error("read request lost");
    fast_done_a: assert property (fl_rd_en && fl_rvalid && fl_done
        && !fl_ecc_db |=> hready_out && !hresp) else $error("late answer");
    word_sel_a: assert property (fl_rd_en && fl_rvalid && fl_done
        && !fl_ecc_db |=> hrdata == $past(fl_rdata[wsel_q*32 +: 32]))
        else $error("wrong word of page");
    err_pair_a: assert property (hresp && !hready_out
        |=> hresp && hready_out) else $error("error not two cycles");
    stall_hold_a: assert property (!fl_done && !hready_out && !hresp
        |=> !hready_out) else $error("data phase ended while busy");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("apb access not answered");
endmodule
bind frw_ctrl frw_ctrl_props frw_ctrl_props_inst (.pclk, .presetn, .hsel,
    .hwrite, .hready_in, .haddr, .htrans, .hready_out, .hresp, .hrdata,
    .fl_rd_en, .fl_abort, .fl_done, .fl_rvalid, .fl_ecc_db, .fl_page,
    .fl_rdata, .psel, .penable, .pready);
`default_nettype wire

// File: tb/frw_flash_model.sv
// frw_flash_model: behavioural single-bank array behind the read path.
// assumes the bench starts program/erase with op_start and op_len.
`timescale 1ns/1ns
`default_nettype none
module frw_flash_model
    import frw_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic op_start,
    input wire logic [7:0] op_len,
    input wire logic [1:0] rd_lat,
    input wire logic ecc_bad,
    // array pins
    input wire logic fl_rd_en,
    input wire logic [AHB_AW-1:PAGE_LO] fl_page,
    input wire logic fl_abort,
    output logic fl_done,
    output logic fl_rvalid,
    output logic [PAGE_W-1:0] fl_rdata,
    output logic fl_ecc_sb,
    output logic fl_ecc_db
);
    logic [7:0] busy_q, busy_d; // cycles left of high-voltage op
    logic [1:0] lat_q, lat_d; // read access counter
    logic vld_q, vld_d; // page valid pulse
    logic [PAGE_W-1:0] pg_q, pg_d; // page being returned
    // ====================
    // next state: busy count and page read
    always_comb begin
        busy_d = busy_q;
        lat_d = 2'h0;
        vld_d = 1'b0;
        pg_d = pg_q;
        if (op_start)
            busy_d = op_len; // done low for whole op
        else if (fl_abort && busy_q > 8'h03)
            busy_d = 8'h03; // abort cuts op short
        else if (busy_q != 8'h00)
            busy_d = busy_q - 8'h01;
        if (fl_rd_en && fl_done && !vld_q) begin // no read while busy
            if (lat_q == rd_lat) begin
                vld_d = 1'b1; // whole page, word k at bits 32k
                pg_d = {fl_page, 4'hC, fl_page, 4'h8, fl_page, 4'h4,
                        fl_page, 4'h0};
            end else begin
                lat_d = lat_q + 2'h1;
            end
        end
    end
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 8'h00;
            lat_q <= 2'h0;
            vld_q <= 1'b0;
            pg_q <= '0;
        end else begin
            busy_q <= busy_d;
            lat_q <= lat_d;
            vld_q <= vld_d;
            pg_q <= pg_d;
        end
    end
    assign fl_done = (busy_q == 8'h00);
    assign fl_rvalid = vld_q;
    assign fl_rdata = vld_q ? pg_q : ~pg_q; // stale data inverted
    assign fl_ecc_db = vld_q & ecc_bad; // double error only on command
    assign fl_ecc_sb = 1'b0;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench for the flash read path.
// assumes frw_ctrl, the array model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import frw_pkg::*;
    logic pclk, presetn, hsel, hwrite, psel, penable, pwrite, op_start;
    logic ecc_bad, saw_abort, hready_out, hresp, pready, pslverr;
    logic fl_rd_en, fl_abort, fl_done, fl_rvalid, fl_ecc_sb, fl_ecc_db;
    logic notify_irq;
    logic [31:0] haddr, pwdata, prdata, hrdata;
    logic [1:0] htrans, rd_lat;
    logic [11:0] paddr;
    logic [7:0] op_len;
    logic [AHB_AW-1:PAGE_LO] fl_page;
    logic [PAGE_W-1:0] fl_rdata;
    logic [LOCK_W-1:0] fl_block_lock;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    // ====================
    // design and array model
    frw_ctrl frw_ctrl_inst (.pclk, .presetn, .hsel, .haddr, .htrans,
        .hwrite, .hready_in(1'b1), .hready_out, .hresp, .hrdata, .fl_rd_en,
        .fl_page, .fl_abort, .fl_done, .fl_rvalid, .fl_rdata, .fl_ecc_sb,
        .fl_ecc_db, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fl_block_lock, .notify_irq);
    frw_flash_model frw_flash_model_inst (.pclk, .presetn, .op_start,
        .op_len, .rd_lat, .ecc_bad, .fl_rd_en, .fl_page, .fl_abort,
        .fl_done, .fl_rvalid, .fl_rdata, .fl_ecc_sb, .fl_ecc_db);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // timeout and abort watch
    always @(posedge pclk) begin
        cyc++;
        if (fl_abort === 1'b1) saw_abort = 1'b1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ====================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // apb transfer; reads compare data unless an error is expected
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, exp, input logic er);
        int t;
        logic [31:0] rd;
        logic se;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        // look at pready mid-cycle, away from the edge that launches it
        do begin @(negedge pclk); t++; end while (pready !== 1'b1 && t < 50);
        if (t >= 50) n_mismatch++;
        rd = prdata;
        se = pslverr;
        @(posedge pclk);
        if (!wr) check("pslverr", {31'h0, se}, {31'h0, er});
        if (!wr && !er) check("prdata", rd, exp);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // n pipelined ahb transfers from a upward by words
    task automatic ahb(input logic [31:0] a, input int n,
                       input logic wr, er);
        int k, t;
        logic [31:0] rd;
        logic rs;
        @(posedge pclk);
        hsel <= 1'b1; htrans <= HTRANS_NSEQ; haddr <= a; hwrite <= wr;
        t = 0;
        // ready is sampled mid-cycle, then the address is taken at the edge
        do begin @(negedge pclk); t++; end
        while (hready_out !== 1'b1 && t < 400);
        @(posedge pclk);
        for (k = 0; k < n; k++) begin
            if (k + 1 < n) haddr <= a + 32'(4 * (k + 1));
            else htrans <= 2'h0;
            t = 0;
            do begin @(negedge pclk); t++; end
            while (hready_out !== 1'b1 && t < 400);
            if (t >= 400) n_mismatch++;
            rd = hrdata;
            rs = hresp;
            @(posedge pclk);
            check("hresp", {31'h0, rs}, {31'h0, er});
            if (!er) check("hrdata", rd, a + 32'(4 * k));
        end
        hsel <= 1'b0;
    endtask
    // ====================
    // scenarios
    task automatic t_regs;
        apb(0, CFG_OFS, 0, 32'h7, 0);
        apb(0, CAP_OFS, 0, CAP_VAL, 0);
        apb(0, LOCK_OFS, 0, 32'h0000FFFF, 0);
        apb(1, LOCK_OFS, 32'h00F0, 0, 0);
        @(negedge pclk);
        check("lock", {16'h0, fl_block_lock}, 32'h00F0);
        apb(1, CAP_OFS, 32'h0, 0, 0);
        apb(0, CAP_OFS, 0, CAP_VAL, 0);
        apb(0, 12'h010, 0, 0, 1);
    endtask
    task automatic t_plain;
        ahb(32'h0000_0108, 4, 0, 0);
        rd_lat <= 2'h2;
        ahb(32'h0000_0124, 2, 0, 0);
    endtask
    // done falls while the read waits on a slow array
    task automatic t_rww(input logic [2:0] cfg);
        logic [31:0] fl;
        apb(1, CFG_OFS, {29'h0, cfg}, 0, 0);
        saw_abort = 1'b0;
        rd_lat <= 2'h3;
        fork
            ahb(32'h0000_0240, 2, 0, 0);
            begin
                repeat (3) @(posedge pclk);
                op_start <= 1'b1;
                @(posedge pclk);
                op_start <= 1'b0;
            end
        join
        fl = (cfg == 3'h6) ? 32'h1 : (cfg == 3'h4) ? 32'h2 : 32'h0;
        apb(0, STAT_OFS, 0, fl | 32'h100, 0);
        check("irq", {31'h0, notify_irq}, {31'h0, fl != 0});
        check("abort", {31'h0, saw_abort}, {31'h0, !cfg[1]});
        apb(1, STAT_OFS, 32'hF, 0, 0);
    endtask
    // error setting, refused writes and a double-bit error
    task automatic t_err;
        int t;
        apb(1, CFG_OFS, 32'h3, 0, 0);
        op_start <= 1'b1;
        @(posedge pclk);
        op_start <= 1'b0;
        ahb(32'h0000_0300, 2, 0, 1);
        ahb(32'h0000_0304, 1, 1, 1);
        t = 0;
        while (fl_done !== 1'b1 && t < 200) begin @(posedge pclk); t++; end
        ecc_bad <= 1'b1;
        ahb(32'h0000_0310, 1, 0, 1);
        ecc_bad <= 1'b0;
        apb(0, STAT_OFS, 0, 32'h108, 0);
    endtask
    initial begin
        presetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        op_start = 0; op_len = 8'h3C; rd_lat = 0; ecc_bad = 0;
        saw_abort = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // outputs after reset: idle bus, no abort, no request
        @(negedge pclk);
        check("rst hready", {31'h0, hready_out}, 32'h1);
        check("rst abort", {31'h0, fl_abort}, 32'h0);
        check("rst irq", {31'h0, notify_irq}, 32'h0);
        t_regs();
        t_plain();
        t_rww(3'h7);
        t_rww(3'h6);
        t_rww(3'h5);
        t_rww(3'h4);
        t_err();
        print_verdict();
    end
endmodule
`default_nettype wire
